/* File: hdl/flash_guard_pkg.sv */
// constants shared by the flash page lock guard and its bench
// assumes 8 pages of 2 KB, lock byte at 0x3BFF in page 7, reserved area above it up to the top of page 7
package flash_guard_pkg;

  localparam int unsigned   ADDR_W          = 16;
  localparam int unsigned   PAGE_SHIFT      = 11;
  localparam int unsigned   PAGE_W          = 3;
  localparam logic [2:0]    LOCK_PAGE       = 3'h7;
  localparam logic [15:0]   LOCK_BYTE_ADDR  = 16'h3BFF;
  localparam logic [15:0]   RESERVED_BASE   = 16'h3C00;
  localparam logic [7:0]    LOCK_ERASED     = 8'hFF;
  localparam logic [7:0]    LOCK_ALL_LOCKED = 8'h00;

  // flash operation codes on the request port
  localparam logic [1:0]    OP_READ         = 2'h0;
  localparam logic [1:0]    OP_WRITE        = 2'h1;
  localparam logic [1:0]    OP_ERASE        = 2'h2;
  localparam logic [1:0]    OP_DEVICE_ERASE = 2'h3;

  // apb register byte offsets
  localparam logic [7:0]    STATUS_OFS      = 8'h00;
  localparam logic [7:0]    MASK_OFS        = 8'h04;
  localparam logic [7:0]    RESET_SRC_OFS   = 8'h08;
  localparam logic [7:0]    LOCK_ACTIVE_OFS = 8'h0C;
  localparam logic [7:0]    LOCK_STORED_OFS = 8'h10;

  // status and mask bit positions
  localparam int unsigned   EV_FW_ERROR     = 0;
  localparam int unsigned   EV_DBG_DROP     = 1;
  localparam int unsigned   EV_LOCK_WRITE   = 2;
  localparam int unsigned   EV_W            = 3;

  // reset-source register field
  localparam int unsigned   RSRC_FLASH_ERR  = 0;

  localparam logic [EV_W-1:0] STATUS_RESET  = 3'h0;
  localparam logic [EV_W-1:0] MASK_RESET    = 3'h0;

  // outcome of one permission decision
  typedef enum logic [2:0] {
    VERDICT_PERMIT = 3'b001,
    VERDICT_DROP   = 3'b010,
    VERDICT_ERROR  = 3'b100
  } verdict_t;

  // apb slave sequencing
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;

endpackage

/* File: hdl/flash_page_lock_guard.sv */
// permission checker for program flash requests from the debug port and firmware
// assumes one request at a time on the request port, apb master on the same clock,
// SRST driven by the system reset logic (which also acts on the error reset pulse),
// PWR_ON high only at power-up; flash contents and the reset-source flag survive SRST
//
// Function
// RULE_01 - unlocked pages other than lock page: all requesters may read, write, erase
// RULE_02 - locked pages: debug refused, unlocked firmware resets, locked firmware allowed
// RULE_03 - lock page read/write open while nothing locked, else treated as locked page
// RULE_04 - lock byte read open while nothing locked, else locked-page treatment
// RULE_05 - nothing locked: debug may erase lock page, firmware erase resets device
// RULE_06 - something locked: lock page erased only by debug device erase; firmware resets
// RULE_07 - locking more pages: debug refused, any firmware resets device
// RULE_08 - unlocking single pages: debug refused, any firmware resets device
// RULE_09 - reserved area access: debug refused, any firmware resets device
// RULE_10 - error reset leaves the flash error flag at one afterwards
// RULE_11 - forbidden debug requests are dropped without any reset
// RULE_12 - any locked page also locks the lock-byte page
// RULE_13 - once written, lock byte changes only by debug device erase; code also lets debug erase the lock page until the byte is active
// RULE_14 - firmware lock byte write takes effect only after next reset
// RULE_15 - firmware write or erase resets unless supply monitor and its reset enabled
// RULE_16 - debug device erase clears every page including the lock page
// RULE_17 - one lock bit per page, zero locked, all ones nothing locked
// RULE_18 - firmware class follows the lock state of the fetching page
`timescale 1ns/1ns
`default_nettype none

module flash_page_lock_guard (
  input  wire  logic        MCLK,
  input  wire  logic        SRST,
  input  wire  logic        PWR_ON,
  input  wire  logic        REQ_VALID,
  input  wire  logic        REQ_DEBUG,
  input  wire  logic [1:0]  REQ_OP,
  input  wire  logic [15:0] REQ_ADDR,
  input  wire  logic [7:0]  REQ_WDATA,
  input  wire  logic [15:0] FETCH_ADDR,
  input  wire  logic        SUPPLY_MON_EN,
  input  wire  logic        SUPPLY_MON_RST_EN,
  output var   logic        RESP_VALID,
  output var   logic        RESP_PERMIT,
  output var   logic        RESP_DROPPED,
  output var   logic        FLASH_ERROR_DEVICE_RESET,
  output var   logic        IRQ,
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [7:0]  PADDR,
  input  wire  logic [31:0] PWDATA,
  output var   logic [31:0] PRDATA,
  output var   logic        PREADY,
  output var   logic        PSLVERR
);

  // page index of a flash byte address
  function automatic logic [2:0] page_of(input logic [15:0] addr);
    page_of = addr[flash_guard_pkg::PAGE_SHIFT +: flash_guard_pkg::PAGE_W];
  endfunction

  // lock state of a page under a given lock byte
  function automatic logic page_locked(input logic [2:0] page, input logic [7:0] lock);
    logic any;
    any = (lock != flash_guard_pkg::LOCK_ERASED); // see RULE_17
    page_locked = any && (!lock[page] || page == flash_guard_pkg::LOCK_PAGE); // see RULE_12
  endfunction

  // one register per aligned word offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  logic [7:0]                           lock_stored;
  logic [7:0]                           lock_active;
  logic                                 lock_loaded;
  logic [flash_guard_pkg::EV_W-1:0]     status;
  logic [flash_guard_pkg::EV_W-1:0]     mask;
  logic                                 flash_error_reset_flag;
  flash_guard_pkg::apb_state_t          apb_state;

  // request classification
  wire         any_locked   = (lock_active != flash_guard_pkg::LOCK_ERASED);
  wire         fw_locked    = page_locked(page_of(FETCH_ADDR), lock_active); // see RULE_18
  wire         tgt_locked   = page_locked(page_of(REQ_ADDR), lock_active);
  wire         tgt_reserved = (REQ_ADDR >= flash_guard_pkg::RESERVED_BASE);
  wire         tgt_lockpage = (page_of(REQ_ADDR) == flash_guard_pkg::LOCK_PAGE);
  wire         tgt_lockbyte = (REQ_ADDR == flash_guard_pkg::LOCK_BYTE_ADDR);
  wire         is_dev_erase = (REQ_OP == flash_guard_pkg::OP_DEVICE_ERASE);
  wire         is_erase     = (REQ_OP == flash_guard_pkg::OP_ERASE);
  wire         is_write     = (REQ_OP == flash_guard_pkg::OP_WRITE);
  wire         is_modify    = is_write || is_erase;
  wire         supply_ok    = SUPPLY_MON_EN && SUPPLY_MON_RST_EN;
  wire         lock_written = (lock_stored != flash_guard_pkg::LOCK_ERASED);
  wire         lock_change  = is_write && tgt_lockbyte && lock_written;

  // refusal for a forbidden request: debug drops, firmware resets
  flash_guard_pkg::verdict_t forbid;
  always_comb
  begin
    if (REQ_DEBUG)
      forbid = flash_guard_pkg::VERDICT_DROP;
    else
      forbid = flash_guard_pkg::VERDICT_ERROR;
  end

  // normal page treatment: open unless the page is locked and the requester is not locked firmware
  flash_guard_pkg::verdict_t page_rule;
  always_comb
  begin
    if (!tgt_locked || (!REQ_DEBUG && fw_locked))
      page_rule = flash_guard_pkg::VERDICT_PERMIT;
    else
      page_rule = forbid;
  end

  flash_guard_pkg::verdict_t verdict;

  always_comb
  begin
    if (!lock_loaded)
      // lock state not yet known after reset; refuse rather than guess
      verdict = forbid;
    else if (is_dev_erase)
      verdict = REQ_DEBUG ? flash_guard_pkg::VERDICT_PERMIT
                          : flash_guard_pkg::VERDICT_ERROR; // see RULE_16
    else if (tgt_reserved)
      verdict = forbid; // see RULE_09
    else if (!REQ_DEBUG && is_modify && !supply_ok)
      verdict = flash_guard_pkg::VERDICT_ERROR; // see RULE_15
    else if (is_erase && tgt_lockpage)
      // firmware never erases it; debug only while nothing is locked
      verdict = (REQ_DEBUG && !any_locked) ? flash_guard_pkg::VERDICT_PERMIT
                                           : forbid; // see RULE_05 see RULE_06
    else if (lock_change)
      verdict = forbid; // see RULE_07 see RULE_08 see RULE_13
    else
      verdict = page_rule; // see RULE_01 see RULE_02 see RULE_03 see RULE_04
  end

  wire req_permit = REQ_VALID && (verdict == flash_guard_pkg::VERDICT_PERMIT);
  wire req_drop   = REQ_VALID && (verdict == flash_guard_pkg::VERDICT_DROP); // see RULE_11
  wire req_error  = REQ_VALID && (verdict == flash_guard_pkg::VERDICT_ERROR);

  // lock byte storage effects of permitted requests
  wire lock_erase = req_permit && (is_dev_erase || (is_erase && tgt_lockpage));
  wire lock_write = req_permit && is_write && tgt_lockbyte;

  logic [7:0] next_lock_stored;
  always_comb
  begin
    if (lock_erase)
      next_lock_stored = flash_guard_pkg::LOCK_ERASED;
    else if (lock_write)
      next_lock_stored = REQ_WDATA;
    else
      next_lock_stored = lock_stored;
  end

  // stored lock byte is nonvolatile; SRST keeps it, power-up or a permitted device erase or lock page erase returns it to erased
  always_ff @(posedge MCLK)
  begin
    if (PWR_ON)
      lock_stored <= flash_guard_pkg::LOCK_ERASED;
    else
      lock_stored <= next_lock_stored; // see RULE_16
  end

  // active lock state only follows storage at reset release
  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      lock_active <= flash_guard_pkg::LOCK_ALL_LOCKED;
    else if (!lock_loaded)
      lock_active <= lock_stored; // see RULE_14
  end

  // one refused cycle after reset, traded for never deciding on a stale lock
  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      lock_loaded <= 1'b0;
    else
      lock_loaded <= 1'b1;
  end

  // error flag survives the reset it causes
  always_ff @(posedge MCLK)
  begin
    if (PWR_ON)
      flash_error_reset_flag <= 1'b0;
    else if (req_error)
      flash_error_reset_flag <= 1'b1; // see RULE_10
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      RESP_VALID <= 1'b0;
    else
      RESP_VALID <= REQ_VALID;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      RESP_PERMIT <= 1'b0;
    else
      RESP_PERMIT <= req_permit;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      RESP_DROPPED <= 1'b0;
    else
      RESP_DROPPED <= req_drop;
  end

  // the system reset logic turns this pulse into SRST
  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      FLASH_ERROR_DEVICE_RESET <= 1'b0;
    else
      FLASH_ERROR_DEVICE_RESET <= req_error; // see RULE_02 see RULE_15
  end

  // apb slave: one wait state, pready from a flop
  wire        apb_access = PSEL && PENABLE;
  wire        apb_fire   = apb_access && PREADY;
  wire        apb_wr     = apb_fire && PWRITE;
  wire        sel_status = reg_hit(PADDR, flash_guard_pkg::STATUS_OFS);
  wire        sel_mask   = reg_hit(PADDR, flash_guard_pkg::MASK_OFS);
  wire        sel_rsrc   = reg_hit(PADDR, flash_guard_pkg::RESET_SRC_OFS);
  wire        sel_lact   = reg_hit(PADDR, flash_guard_pkg::LOCK_ACTIVE_OFS);
  wire        sel_lsto   = reg_hit(PADDR, flash_guard_pkg::LOCK_STORED_OFS);
  wire        sel_any    = sel_status || sel_mask || sel_rsrc || sel_lact || sel_lsto;

  logic [31:0] rd_mux;
  always_comb
  begin
    if (sel_status)
      rd_mux = {29'h0, status};
    else if (sel_mask)
      rd_mux = {29'h0, mask};
    else if (sel_rsrc)
      rd_mux = {31'h0, flash_error_reset_flag};
    else if (sel_lact)
      rd_mux = {24'h0, lock_active};
    else if (sel_lsto)
      rd_mux = {24'h0, lock_stored};
    else
      rd_mux = 32'h0;
  end

  logic [flash_guard_pkg::EV_W-1:0] events;
  assign events[flash_guard_pkg::EV_FW_ERROR]   = req_error;
  assign events[flash_guard_pkg::EV_DBG_DROP]   = req_drop;
  assign events[flash_guard_pkg::EV_LOCK_WRITE] = lock_write;

  // set wins over a write-one clear in the same cycle
  logic [flash_guard_pkg::EV_W-1:0] w1c;
  assign w1c = (apb_wr && sel_status) ? PWDATA[flash_guard_pkg::EV_W-1:0]
                                      : {flash_guard_pkg::EV_W{1'b0}};

  logic [flash_guard_pkg::EV_W-1:0] next_status;
  assign next_status = (status & ~w1c) | events;

  logic [flash_guard_pkg::EV_W-1:0] next_mask;
  assign next_mask = (apb_wr && sel_mask) ? PWDATA[flash_guard_pkg::EV_W-1:0] : mask;

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      status <= flash_guard_pkg::STATUS_RESET;
    else
      status <= next_status;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      mask <= flash_guard_pkg::MASK_RESET;
    else
      mask <= next_mask;
  end

  // a new mask takes hold one cycle after its write
  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      IRQ <= 1'b0;
    else
      IRQ <= |(next_status & mask);
  end

  flash_guard_pkg::apb_state_t          next_apb_state;
  logic                                 next_pready;
  logic [31:0]                          next_prdata;
  logic                                 next_pslverr;

  always_comb
  begin
    next_apb_state = apb_state;
    next_pready    = PREADY;
    next_prdata    = PRDATA;
    next_pslverr   = PSLVERR;
    case (apb_state)
      flash_guard_pkg::APB_IDLE:
      begin
        if (apb_access)
        begin
          next_apb_state = flash_guard_pkg::APB_DONE;
          next_pready    = 1'b1;
          next_prdata    = PWRITE ? 32'h0 : rd_mux;
          // writes to read-only registers and any access to holes answer with an error
          next_pslverr   = !sel_any || (PWRITE && !(sel_status || sel_mask));
        end
      end
      flash_guard_pkg::APB_DONE:
      begin
        next_apb_state = flash_guard_pkg::APB_IDLE;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
      end
      default:
      begin
        next_apb_state = flash_guard_pkg::APB_IDLE;
        next_pready    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      apb_state <= flash_guard_pkg::APB_IDLE;
    else
      apb_state <= next_apb_state;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      PREADY <= 1'b0;
    else
      PREADY <= next_pready;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      PRDATA <= 32'h0;
    else
      PRDATA <= next_prdata;
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST || PWR_ON)
      PSLVERR <= 1'b0;
    else
      PSLVERR <= next_pslverr;
  end

endmodule

`default_nettype wire

/* File: dv/flash_guard_checker.sv */
// assertions on the request port of the flash page lock guard
// assumes a bind to flash_page_lock_guard; only its ports are seen
`timescale 1ns/1ns
`default_nettype none
module flash_guard_checker (
  input wire logic        MCLK,
  input wire logic        SRST,
  input wire logic        PWR_ON,
  input wire logic        REQ_VALID,
  input wire logic        REQ_DEBUG,
  input wire logic [1:0]  REQ_OP,
  input wire logic [15:0] REQ_ADDR,
  input wire logic        SUPPLY_MON_EN,
  input wire logic        SUPPLY_MON_RST_EN,
  input wire logic        RESP_VALID,
  input wire logic        RESP_PERMIT,
  input wire logic        RESP_DROPPED,
  input wire logic        FLASH_ERROR_DEVICE_RESET
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST || PWR_ON);
  wire [2:0] verdict = {RESP_PERMIT, RESP_DROPPED, FLASH_ERROR_DEVICE_RESET};
  wire       fw      = REQ_VALID && !REQ_DEBUG;
  wire       rsvd    = REQ_ADDR >= flash_guard_pkg::RESERVED_BASE;

  a_answer_next:
    assert property (REQ_VALID |=> RESP_VALID && $onehot(verdict))
      else $error("request without a single verdict");
  a_no_stray:
    assert property (!REQ_VALID |=> !RESP_VALID && verdict == 3'h0)
      else $error("verdict without request");
  a_debug_quiet:
    assert property (REQ_VALID && REQ_DEBUG |=> !FLASH_ERROR_DEVICE_RESET)
      else $error("debug request caused reset");
  a_reserved_shut:
    assert property (REQ_VALID && rsvd && REQ_OP != 2'h3 |=> !RESP_PERMIT)
      else $error("reserved area access permitted");
  a_supply_gate:
    assert property (fw && REQ_OP != 2'h0 && !(SUPPLY_MON_EN && SUPPLY_MON_RST_EN)
      |=> FLASH_ERROR_DEVICE_RESET) else $error("unguarded firmware modify");
  a_fw_wipe_err:
    assert property (fw && REQ_OP == 2'h3 |=> FLASH_ERROR_DEVICE_RESET)
      else $error("firmware device erase not reset");
  a_dbg_wipe_ok:
    assert property (REQ_VALID && REQ_DEBUG && REQ_OP == 2'h3 |=> RESP_PERMIT)
      else $error("debug device erase refused");
  a_fw_lockpg_erase:
    assert property (fw && REQ_OP == 2'h2 && REQ_ADDR[13:11] == 3'h7 && !rsvd
      |=> FLASH_ERROR_DEVICE_RESET) else $error("firmware lock page erase not reset");
endmodule

bind flash_page_lock_guard flash_guard_checker chk (
  .MCLK(MCLK), .SRST(SRST), .PWR_ON(PWR_ON), .REQ_VALID(REQ_VALID),
  .REQ_DEBUG(REQ_DEBUG), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
  .SUPPLY_MON_EN(SUPPLY_MON_EN), .SUPPLY_MON_RST_EN(SUPPLY_MON_RST_EN),
  .RESP_VALID(RESP_VALID), .RESP_PERMIT(RESP_PERMIT), .RESP_DROPPED(RESP_DROPPED),
  .FLASH_ERROR_DEVICE_RESET(FLASH_ERROR_DEVICE_RESET)
);
`default_nettype wire

/* File: dv/flash_requester.sv */
// model of the firmware access path and debug host on the request port
// assumes one request per call, launched right after a rising edge
`timescale 1ns/1ns
`default_nettype none
module flash_requester (
  input  wire logic        mclk,
  output var  logic        req_valid,
  output var  logic        req_debug,
  output var  logic [1:0]  req_op,
  output var  logic [15:0] req_addr,
  output var  logic [7:0]  req_wdata,
  output var  logic [15:0] fetch_addr
);
  initial {req_valid, req_debug, req_op, req_addr, req_wdata, fetch_addr} = '0;

  task automatic issue(input logic d, input logic [1:0] op, input logic [15:0] a,
                       input logic [7:0] w, input logic [15:0] f);
    @(posedge mclk);
    {req_valid, req_debug, req_op} <= {1'b1, d, op};
    {req_addr, req_wdata, fetch_addr} <= {a, w, f};
    @(posedge mclk);
    req_valid <= 1'b0;
    // released address and write data lines must not keep the last value
    {req_addr, req_wdata} <= ~{a, w};
  endtask
endmodule
`default_nettype wire

/* File: dv/flash_page_lock_guard_tb.sv */
// self-checking bench for the flash page lock guard
// assumes package, guard, checker and request model compiled first
`timescale 1ns/1ns
`default_nettype none
module flash_page_lock_guard_tb;
  logic        mclk = 1'b0, srst = 1'b1, pwr_on = 1'b1, mon_en = 1'b0, mon_rst_en = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flag = 1'b0;
  logic [7:0]  paddr = 8'h00, req_wdata, act = 8'hFF, stored = 8'hFF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, resp_valid, resp_permit, resp_dropped, fe_reset, irq;
  logic        req_valid, req_debug, slverr;
  logic [1:0]  req_op;
  logic [15:0] req_addr, fetch_addr;
  int          err_count = 0, checked = 0;

  always #2 mclk = ~mclk;

  flash_requester host (.mclk(mclk), .req_valid(req_valid), .req_debug(req_debug),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .fetch_addr(fetch_addr));
  flash_page_lock_guard dut (
    .MCLK(mclk), .SRST(srst), .PWR_ON(pwr_on), .REQ_VALID(req_valid),
    .REQ_DEBUG(req_debug), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .FETCH_ADDR(fetch_addr), .SUPPLY_MON_EN(mon_en), .SUPPLY_MON_RST_EN(mon_rst_en),
    .RESP_VALID(resp_valid), .RESP_PERMIT(resp_permit), .RESP_DROPPED(resp_dropped),
    .FLASH_ERROR_DEVICE_RESET(fe_reset), .IRQ(irq), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    slverr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic sys_reset;
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    act = stored;
    @(posedge mclk);
  endtask

  // expected {valid, permit, dropped, error} in the guard's decision order
  function automatic logic [3:0] expect_of(logic d, logic [1:0] op, logic [15:0] a,
                                           logic [15:0] f);
    logic any, pl, fl, ok;
    any = act != 8'hFF;
    pl = any && (!act[a[13:11]] || a[13:11] == 3'h7);
    fl = any && (!act[f[13:11]] || f[13:11] == 3'h7);
    if (op == 2'h3) ok = d;
    else if (a >= flash_guard_pkg::RESERVED_BASE) ok = 1'b0;
    else if (!d && op != 2'h0 && !(mon_en && mon_rst_en)) ok = 1'b0;
    else if (op == 2'h2 && a[13:11] == 3'h7) ok = d && !any;
    else if (op == 2'h1 && a == flash_guard_pkg::LOCK_BYTE_ADDR && stored != 8'hFF) ok = 1'b0;
    else ok = !pl || (!d && fl);
    return {1'b1, ok, !ok && d, !ok && !d};
  endfunction

  task automatic one(logic d, logic [1:0] op, logic [15:0] a, logic [7:0] w, logic [15:0] f);
    logic [3:0] e;
    host.issue(d, op, a, w, f);
    e = expect_of(d, op, a, f);
    #1 cmp("verdict", e, {resp_valid, resp_permit, resp_dropped, fe_reset});
    if (e[2] && (op == 2'h3 || (op == 2'h2 && a[13:11] == 3'h7))) stored = 8'hFF;
    if (e[2] && op == 2'h1 && a == flash_guard_pkg::LOCK_BYTE_ADDR) stored = w;
    if (e[0])
    begin
      flag = 1'b1;
      sys_reset;
    end
  endtask

  initial
  begin
    logic [15:0] a;
    logic [1:0]  op;
    void'($urandom(29614));
    repeat (16) @(posedge mclk);
    {srst, pwr_on} <= 2'b00;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      cmp("reg reset", (i < 3) ? 32'h0 : 32'h0000_00FF, rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, slverr});
    apb(1'b1, 8'h10, 32'h0);
    cmp("ro write err", 32'h1, {31'h0, slverr});
    one(1'b1, 2'h0, 16'h3C10, 8'h00, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 cmp("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h04, 32'h2);
    repeat (2) @(posedge mclk);
    #1 cmp("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge mclk);
    #1 cmp("irq clear", 32'h0, {31'h0, irq});
    for (int n = 0; n < 400; n++)
    begin
      @(posedge mclk);
      mon_en <= ($urandom % 8) != 0;
      mon_rst_en <= ($urandom % 8) != 0;
      op = ($urandom % 16 == 0) ? 2'h3 : 2'($urandom % 3);
      a = ($urandom % 4 == 0) ? flash_guard_pkg::LOCK_BYTE_ADDR : 16'($urandom % 16'h4000);
      one(1'($urandom), op, a, 8'($urandom), 16'($urandom % 16'h3C00));
      if (n % 32 == 31)
      begin
        apb(1'b0, 8'h0C, 32'h0);
        cmp("active lock", {24'h0, act}, rd);
        apb(1'b0, 8'h10, 32'h0);
        cmp("stored lock", {24'h0, stored}, rd);
        apb(1'b0, 8'h08, 32'h0);
        cmp("error flag", {31'h0, flag}, rd);
        sys_reset;
      end
    end
    give_verdict;
  end

  initial
  begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
